//--- design/reset_timer.sv
`timescale 1ns/1ns
// counts i_length cycles after start (16 when i_length is zero) and pulses done
module reset_timer (
	input  wire logic       i_core_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_start,
	input  wire logic [3:0] i_length,
	output logic            o_busy,
	output logic            o_done
);
	logic [3:0] count;

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			count  <= 4'h0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_start) begin
				count  <= i_length;
				o_busy <= 1'b1;
			end else if (o_busy) begin
				if (count == 4'h1) begin
					o_busy <= 1'b0;
					o_done <= 1'b1;
				end
				count <= count - 4'h1;
			end
		end
	end
endmodule

//--- design/serdes_port_control_pkg.sv
// Operation
// R1: port control register sits at register 0 of page 4.
// R2: writing bit 15 resets port state machines; bit clears itself when done.
// R3: bit 14 loops internal transmit data back to receive and drops link.
// R4: speed is bits 6,13; writable only in media mode, else tracks network.
// R5: hardware reset loads speed 1000 Mbps: bit 6 one, bit 13 zero.
// R6: changing autoneg enable bit 12 breaks link, sets restart; reset loads strap.
// R7: power-down bit 11 resets to one only if strap set and mode is 101.
// R8: self-clearing bit 9 restarts autonegotiation; set on enable toggle.
// R9: autoneg restarts after hardware reset, port reset and enable change.
// R10: mode select bit 0 of page 4 register 16: zero system, one media.
package serdes_port_control_pkg;
	localparam logic [2:0]  PAGE_PORT       = 3'h4;
	localparam logic [4:0]  REG_CONTROL     = 5'h00;
	localparam logic [4:0]  REG_MODE        = 5'h10;
	localparam logic [7:0]  ADDR_CONTROL    = {PAGE_PORT, REG_CONTROL};
	localparam logic [7:0]  ADDR_MODE       = {PAGE_PORT, REG_MODE};
	localparam int          BIT_RESET       = 15;
	localparam int          BIT_LOOPBACK    = 14;
	localparam int          BIT_SPEED_LSB   = 13;
	localparam int          BIT_AN_ENABLE   = 12;
	localparam int          BIT_POWERDOWN   = 11;
	localparam int          BIT_RESERVED_RW = 10;
	localparam int          BIT_AN_RESTART  = 9;
	localparam int          BIT_FIXED_ONE   = 8;
	localparam int          BIT_SPEED_MSB   = 6;
	localparam int          BIT_MODE_MEDIA  = 0;
	localparam logic [2:0]  MODE_PD_ALLOWED = 3'h5;
	localparam logic [1:0]  SPEED_1000      = 2'h2;
	localparam logic [1:0]  SPEED_100       = 2'h1;
	localparam logic [3:0]  RESET_CYCLES    = 4'h8;
	localparam logic [15:0] READ_ZERO       = 16'h0000;
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_RESET   = 2'b01,
		ST_RESTART = 2'b10
	} port_state_type;
endpackage

//--- design/serdes_port_control_register.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
module serdes_port_control_register
	import serdes_port_control_pkg::*;
(
	input  wire logic       i_core_clk,
	input  wire logic       i_sys_rst,
	input  wire logic [7:0] i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic     [15:0] o_rdata,
	input  wire logic       i_autoneg_strap,
	input  wire logic       i_powerdown_strap,
	input  wire logic [2:0] i_config_mode_strap,
	input  wire logic [1:0] i_network_speed,
	output logic            o_port_reset,
	output logic            o_loopback,
	output logic            o_link_break,
	output logic            o_autoneg_enable,
	output logic            o_autoneg_restart,
	output logic            o_powerdown,
	output logic [1:0]      o_speed,
	output logic            o_media_mode
);
	import serdes_port_control_pkg::*;

	// straps and network speed come from pins, so they pass two flops
	logic [1:0] an_strap_sync;
	logic [1:0] pd_strap_sync;
	logic [5:0] mode_strap_sync;
	logic [3:0] speed_sync;
	logic       strap_taken;
	logic       loopback;
	logic       an_enable;
	logic       powerdown;
	logic       reserved_rw;
	logic       media_mode;
	logic [1:0] speed;
	logic       restart_req;
	logic       timer_busy;
	logic       timer_done;
	logic       wr_ctrl;
	logic       wr_mode;
	logic       sw_reset_start;
	logic       an_toggle;
	port_state_type state;

	assign wr_ctrl        = i_wr && (i_addr == ADDR_CONTROL);
	assign wr_mode        = i_wr && (i_addr == ADDR_MODE);
	assign sw_reset_start = wr_ctrl && i_wdata[BIT_RESET] && (state != ST_RESET);
	assign an_toggle      = wr_ctrl && strap_taken && (i_wdata[BIT_AN_ENABLE] != an_enable);

	function automatic logic [15:0] control_word(input logic rst_b, input logic [1:0] spd);
		logic [15:0] w;
		w = READ_ZERO;
		w[BIT_RESET]       = rst_b;
		w[BIT_LOOPBACK]    = loopback;
		w[BIT_SPEED_LSB]   = spd[0];
		w[BIT_AN_ENABLE]   = an_enable;
		w[BIT_POWERDOWN]   = powerdown;
		w[BIT_RESERVED_RW] = reserved_rw;
		w[BIT_AN_RESTART]  = restart_req;
		w[BIT_FIXED_ONE]   = 1'b1;
		w[BIT_SPEED_MSB]   = spd[1];
		return w;
	endfunction

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			an_strap_sync   <= 2'h0;
			pd_strap_sync   <= 2'h0;
			mode_strap_sync <= 6'h00;
			speed_sync      <= 4'h0;
		end else begin
			an_strap_sync   <= {an_strap_sync[0], i_autoneg_strap};
			pd_strap_sync   <= {pd_strap_sync[0], i_powerdown_strap};
			mode_strap_sync <= {mode_strap_sync[2:0], i_config_mode_strap};
			speed_sync      <= {speed_sync[1:0], i_network_speed};
		end
	end

	// straps are captured once the sync chain has filled after reset release
	logic [1:0] strap_wait;
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			strap_wait  <= 2'h0;
			strap_taken <= 1'b0;
		end else if (!strap_taken) begin
			strap_wait  <= strap_wait + 2'h1;
			strap_taken <= (strap_wait == 2'h2);
		end
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			an_enable <= 1'b0;
			powerdown <= 1'b0;
		end else if (!strap_taken) begin
			if (strap_wait == 2'h2) begin
				an_enable <= an_strap_sync[1]; // [R6]
				powerdown <= pd_strap_sync[1] && (mode_strap_sync[5:3] == MODE_PD_ALLOWED); // [R7]
			end
		end else if (wr_ctrl) begin
			an_enable <= i_wdata[BIT_AN_ENABLE];
			powerdown <= i_wdata[BIT_POWERDOWN];
		end
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			loopback    <= 1'b0;
			reserved_rw <= 1'b0;
		end else if (sw_reset_start) begin
			loopback    <= 1'b0;
		end else if (wr_ctrl) begin
			loopback    <= i_wdata[BIT_LOOPBACK]; // [R3]
			reserved_rw <= i_wdata[BIT_RESERVED_RW];
		end
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			media_mode <= 1'b0;
		end else if (wr_mode) begin
			media_mode <= i_wdata[BIT_MODE_MEDIA]; // [R10]
		end
	end

	// system mode tracks the network; media mode keeps the written value
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			speed <= SPEED_1000; // [R5]
		end else if (!media_mode) begin
			speed <= speed_sync[3:2]; // [R4]
		end else if (wr_ctrl) begin
			speed <= {i_wdata[BIT_SPEED_MSB], i_wdata[BIT_SPEED_LSB]}; // [R4]
		end
	end

	reset_timer u_reset_timer (
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.i_start    (sw_reset_start),
		.i_length   (RESET_CYCLES),
		.o_busy     (timer_busy),
		.o_done     (timer_done)
	);

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state <= ST_RESTART;
		end else begin
			case (state)
				ST_IDLE: begin
					if (sw_reset_start) begin
						state <= ST_RESET; // [R2]
					end
				end
				ST_RESET: begin
					if (timer_done) begin
						state <= ST_RESTART; // [R9]
					end
				end
				ST_RESTART: begin
					if (sw_reset_start) begin
						state <= ST_RESET;
					end else if (strap_taken) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// restart is a one-cycle request; set wins over self clear
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			restart_req <= 1'b0;
		end else begin
			restart_req <= (wr_ctrl && i_wdata[BIT_AN_RESTART]) || an_toggle
				|| (state == ST_RESTART && strap_taken && !sw_reset_start); // [R8] [R9] [R6]
		end
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_port_reset      <= 1'b1;
			o_loopback        <= 1'b0;
			o_link_break      <= 1'b0;
			o_autoneg_enable  <= 1'b0;
			o_autoneg_restart <= 1'b0;
			o_powerdown       <= 1'b0;
			o_speed           <= SPEED_1000;
			o_media_mode      <= 1'b0;
		end else begin
			o_port_reset      <= (state == ST_RESET) || timer_busy; // [R2]
			o_loopback        <= loopback; // [R3]
			o_link_break      <= loopback || an_toggle; // [R3] [R6]
			o_autoneg_enable  <= an_enable;
			o_autoneg_restart <= restart_req; // [R8]
			o_powerdown       <= powerdown;
			o_speed           <= speed;
			o_media_mode      <= media_mode;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rdata <= READ_ZERO;
		end else if (i_rd && i_addr == ADDR_CONTROL) begin
			o_rdata <= control_word(state == ST_RESET, speed); // [R1]
		end else if (i_rd && i_addr == ADDR_MODE) begin
			o_rdata <= {15'h0000, media_mode};
		end else begin
			o_rdata <= READ_ZERO;
		end
	end

	sequence seq_reset_write;
		wr_ctrl && i_wdata[BIT_RESET] && state == ST_IDLE;
	endsequence

	AST_RESET_SELF_CLEARS: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R2]
		seq_reset_write |=> (state == ST_RESET) [*8] ##[1:4] (state == ST_RESTART))
		else $error("port reset did not clear itself");
	AST_RESTART_AFTER_RESET: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R9]
		(state == ST_RESET && timer_done) |=> ##1 restart_req)
		else $error("no restart after port reset");
	AST_TOGGLE_RESTARTS: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R6]
		an_toggle |=> restart_req && o_link_break ##1 o_autoneg_restart)
		else $error("enable change did not restart autoneg");
	AST_LOOPBACK_BREAKS: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R3]
		o_loopback |-> o_link_break)
		else $error("loopback without link break");
	AST_SPEED_TRACKS: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R4]
		!media_mode && !$past(media_mode) && !$past(i_sys_rst) |-> speed == $past(speed_sync[3:2]))
		else $error("speed not tracking network in system mode");
	AST_SPEED_WRITE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R4]
		media_mode && wr_mode == 1'b0 && wr_ctrl
			|=> speed == {$past(i_wdata[BIT_SPEED_MSB]), $past(i_wdata[BIT_SPEED_LSB])})
		else $error("speed write lost in media mode");
	AST_RESTART_WRITE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R8]
		wr_ctrl && i_wdata[BIT_AN_RESTART] |=> restart_req ##1 o_autoneg_restart)
		else $error("restart write ignored");
	AST_POWERDOWN_STRAP: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R7]
		$rose(strap_taken)
			|-> powerdown == ($past(pd_strap_sync[1]) && $past(mode_strap_sync[5:3]) == MODE_PD_ALLOWED))
		else $error("powerdown strap not loaded");
endmodule

//--- test/serdes_far_side_model.sv
`timescale 1ns/1ns
// far side: presents the line speed and counts restart requests seen on the port
module serdes_far_side_model (
	input  wire logic       i_core_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_autoneg_restart,
	input  wire logic [1:0] i_line_speed,
	output logic      [1:0] o_network_speed,
	output int              o_restarts
);
	initial o_restarts = 0;
	assign o_network_speed = i_line_speed;
	always @(posedge i_core_clk) begin
		if (!i_sys_rst && i_autoneg_restart === 1'b1)
			o_restarts <= o_restarts + 1;
	end
endmodule

//--- test/serdes_port_control_register_tb.sv
`timescale 1ns/1ns
module serdes_port_control_register_tb;
	import serdes_port_control_pkg::*;
	logic        i_core_clk = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic [7:0]  i_addr = 8'h00;
	logic [15:0] i_wdata = 16'h0000;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic        i_autoneg_strap = 1'b1;
	logic        i_powerdown_strap = 1'b1;
	logic [2:0]  i_config_mode_strap = 3'h5;
	logic [1:0]  line_speed = 2'h1;
	logic [1:0]  i_network_speed;
	logic [15:0] o_rdata;
	logic [1:0]  o_speed;
	logic        o_port_reset, o_loopback, o_link_break, o_autoneg_enable;
	logic        o_autoneg_restart, o_powerdown, o_media_mode;
	logic        rd_q = 1'b0;
	logic [15:0] exp_q[$];
	int          restarts, r0;
	int          n_mismatch = 0;
	int          compares = 0;

	always #2 i_core_clk = ~i_core_clk;

	serdes_port_control_register serdes_port_control_register_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_autoneg_strap(i_autoneg_strap), .i_powerdown_strap(i_powerdown_strap),
		.i_config_mode_strap(i_config_mode_strap), .i_network_speed(i_network_speed),
		.o_port_reset(o_port_reset), .o_loopback(o_loopback), .o_link_break(o_link_break),
		.o_autoneg_enable(o_autoneg_enable), .o_autoneg_restart(o_autoneg_restart),
		.o_powerdown(o_powerdown), .o_speed(o_speed), .o_media_mode(o_media_mode));
	serdes_far_side_model serdes_far_side_model_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
		.i_autoneg_restart(o_autoneg_restart), .i_line_speed(line_speed),
		.o_network_speed(i_network_speed), .o_restarts(restarts));

	task chk(input logic [15:0] seen, input logic [15:0] expd);
		compares++;
		if (seen !== expd) begin
			n_mismatch++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, expd);
		end
	endtask

	task final_report;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge i_core_clk);
		i_rd <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge i_core_clk) begin
		if (rd_q)
			chk(o_rdata, exp_q.pop_front());
		rd_q <= i_rd;
	end

	function automatic logic [15:0] ctl(input logic an, input logic pd);
		return {2'b00, line_speed[0], an, pd, 3'b001, 1'b0, line_speed[1], 6'h00};
	endfunction

	task hw_reset(input logic an, input logic pd, input logic [2:0] m);
		@(posedge i_core_clk);
		i_sys_rst <= 1'b1;
		i_autoneg_strap <= an;
		i_powerdown_strap <= pd;
		i_config_mode_strap <= m;
		repeat (8) @(posedge i_core_clk);
		chk(o_speed, SPEED_1000);
		r0 = restarts;
		i_sys_rst <= 1'b0;
		repeat (30) @(posedge i_core_clk);
		chk(restarts, r0 + 1);
	endtask

	initial begin
		#20000;
		n_mismatch++;
		final_report();
	end

	initial begin
		void'($urandom(26));
		line_speed = ($urandom % 2) ? SPEED_1000 : SPEED_100;
		hw_reset(1'b1, 1'b1, 3'h5);
		rd(ADDR_CONTROL, ctl(1'b1, 1'b1));
		chk(o_powerdown, 1'b1);
		chk(o_autoneg_enable, 1'b1);
		wr(8'h00, 16'hFFFF);
		rd(8'h00, READ_ZERO);
		// system mode: speed bits written opposite to the line must be ignored
		wr(ADDR_CONTROL, {2'b00, ~line_speed[0], 6'h20, ~line_speed[1], 6'h00});
		rd(ADDR_CONTROL, ctl(1'b1, 1'b0));
		wr(ADDR_MODE, 16'h0001);
		rd(ADDR_MODE, 16'h0001);
		r0 = restarts;
		wr(ADDR_CONTROL, 16'h4040);
		repeat (4) @(posedge i_core_clk);
		chk(o_loopback, 1'b1);
		chk(o_link_break, 1'b1);
		chk(o_speed, SPEED_1000);
		chk(o_autoneg_enable, 1'b0);
		chk(o_media_mode, 1'b1);
		repeat (20) @(posedge i_core_clk);
		chk(restarts, r0 + 1);
		rd(ADDR_CONTROL, 16'h4140);
		r0 = restarts;
		wr(ADDR_CONTROL, 16'h2200);
		repeat (10) @(posedge i_core_clk);
		chk(restarts, r0 + 1);
		chk(o_speed, SPEED_100);
		chk(o_loopback, 1'b0);
		r0 = restarts;
		wr(ADDR_CONTROL, 16'hA000);
		rd(ADDR_CONTROL, 16'hA100);
		chk(o_port_reset, 1'b1);
		for (int k = 0; k < 40 && o_port_reset !== 1'b0; k++)
			@(posedge i_core_clk);
		chk(o_port_reset, 1'b0);
		repeat (10) @(posedge i_core_clk);
		chk(restarts, r0 + 1);
		rd(ADDR_CONTROL, 16'h2100);
		hw_reset(1'b0, 1'b1, 3'h4);
		rd(ADDR_CONTROL, ctl(1'b0, 1'b0));
		repeat (3) @(posedge i_core_clk);
		final_report();
	end
endmodule
